// File: hw/sgp_power_ctrl.sv
`timescale 1ns/1ps
module sgp_power_ctrl
  import sgp_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic stopClockRequest_n,
  input wire logic busInitError_n,
  input wire logic systemMgmtInterrupt_n,
  input wire logic softInit_n,
  input wire logic [1:0] localInterruptInputs,
  input wire logic snoopActive,
  input wire logic haltRequest,
  input wire logic enhancedHaltEnable,
  input wire logic ackResponseDone,
  input wire logic eventTaken,
  output logic ackCycleRequest,
  output logic [SGP_NUM_EVENTS-1:0] eventPending,
  output logic stopGranted,
  output logic inSnoop,
  output logic inHalt,
  output logic coreRatioLow,
  output logic voltageIdLow,
  output logic [3:0] powerState
);
  logic [SGP_NUM_EVENTS-1:0] rawEvents;
  logic [SGP_NUM_EVENTS-1:0] syncEvents;
  logic stopReqSync;
  logic snoopSync;
  logic stopReq;

  // These pins are asynchronous to clk; active-low ones are inverted before sync
  sgp_sync #(.WIDTH(SGP_NUM_EVENTS + 2)) uSync (
    .clk(clk),
    .rstn(rstn),
    .asyncIn({snoopActive, ~stopClockRequest_n, localInterruptInputs[1],
      localInterruptInputs[0], ~busInitError_n, ~softInit_n, ~systemMgmtInterrupt_n}),
    .syncOut({snoopSync, stopReqSync, syncEvents})
  );
  assign rawEvents = syncEvents;
  assign stopReq = stopReqSync;

  sgp_state_type state_reg, state_next;
  logic [4:0] grantCnt_reg, grantCnt_next;
  logic [3:0] stepCnt_reg, stepCnt_next;
  logic [SGP_NUM_EVENTS-1:0] latched_reg, latched_next;
  logic [SGP_NUM_EVENTS-1:0] evPrev_reg;
  logic [SGP_NUM_EVENTS-1:0] evRise;
  logic [SGP_NUM_EVENTS-1:0] pend_reg;
  logic ratioLow_reg, ratioLow_next;
  logic vidLow_reg, vidLow_next;
  logic inGrant;
  logic inHaltAny;
  logic replay;
  logic breakEvent;
  logic stepDone;
  logic [1:0] flush_reg;
  logic syncReady;

  assign inGrant = (state_reg == SGP_GRANT) || (state_reg == SGP_GRANT_SNOOP);
  assign inHaltAny = (state_reg == SGP_HALT) || (state_reg == SGP_EHALT);
  assign evRise = rawEvents & ~evPrev_reg;
  // Synchronisers restart at zero after reset; until refilled the stop pin
  // would look released and a reset in stop-grant would wrongly exit
  assign syncReady = (flush_reg == SGP_SYNC_FLUSH);
  // Latched events leave the latch when stop-grant ends
  assign replay = (state_reg == SGP_GRANT) && !stopReq && syncReady;
  assign breakEvent = |rawEvents;
  assign stepDone = (stepCnt_reg == SGP_STEP_CYCLES);

  // Stop-grant event latch; one bit per event caps repeats at one
  genvar gi;
  generate
    for (gi = 0; gi < SGP_NUM_EVENTS; gi++) begin : gEvent
      always_comb begin
        latched_next[gi] = latched_reg[gi];
        if (replay) begin
          latched_next[gi] = 1'b0;
        end else if (inGrant && evRise[gi]) begin
          latched_next[gi] = 1'b1;
        end
      end
    end
  endgenerate

  always_comb begin
    state_next = state_reg;
    grantCnt_next = grantCnt_reg;
    stepCnt_next = stepCnt_reg;
    ratioLow_next = ratioLow_reg;
    vidLow_next = vidLow_reg;
    case (state_reg)
      SGP_NORMAL: begin
        if (stopReq) begin
          state_next = SGP_ACK_REQ;
        end else if (haltRequest) begin
          if (enhancedHaltEnable) begin
            state_next = SGP_EH_RATIO;
            stepCnt_next = 4'h0;
          end else begin
            state_next = SGP_HALT;
          end
        end
      end
      SGP_ACK_REQ: state_next = SGP_ACK_WAIT;
      SGP_ACK_WAIT: begin
        if (ackResponseDone) begin
          state_next = SGP_GRANT_CNT;
          grantCnt_next = 5'd1;
        end
      end
      SGP_GRANT_CNT: begin
        if (grantCnt_reg == SGP_GRANT_DELAY) begin
          state_next = SGP_GRANT;
        end else begin
          grantCnt_next = grantCnt_reg + 5'd1;
        end
      end
      SGP_GRANT: begin
        if (replay) begin
          state_next = SGP_NORMAL;
        end else if (snoopSync) begin
          state_next = SGP_GRANT_SNOOP;
        end
      end
      SGP_GRANT_SNOOP: begin
        if (!snoopSync) begin
          state_next = SGP_GRANT;
        end
      end
      SGP_HALT: begin
        // A stop-clock request is ignored while halted; no acknowledge cycle is requested
        if (breakEvent) begin
          state_next = SGP_NORMAL;
        end else if (snoopSync) begin
          state_next = SGP_HALT_SNOOP;
        end
      end
      SGP_HALT_SNOOP: begin
        if (!snoopSync) begin
          state_next = SGP_HALT;
        end
      end
      SGP_EH_RATIO: begin
        ratioLow_next = SGP_RATIO_LOW;
        stepCnt_next = stepCnt_reg + 4'h1;
        if (stepDone) begin
          state_next = SGP_EH_VID;
          stepCnt_next = 4'h0;
        end
      end
      SGP_EH_VID: begin
        vidLow_next = SGP_VID_LOW;
        stepCnt_next = stepCnt_reg + 4'h1;
        if (stepDone) begin
          state_next = SGP_EHALT;
        end
      end
      SGP_EHALT: begin
        if (breakEvent) begin
          state_next = SGP_EX_VID;
          stepCnt_next = 4'h0;
        end else if (snoopSync) begin
          state_next = SGP_EH_SNOOP;
        end
      end
      SGP_EH_SNOOP: begin
        // Operating point untouched while snooping
        if (!snoopSync) begin
          state_next = SGP_EHALT;
        end
      end
      SGP_EX_VID: begin
        vidLow_next = SGP_VID_FULL;
        stepCnt_next = stepCnt_reg + 4'h1;
        if (stepDone) begin
          state_next = SGP_EX_RATIO;
          stepCnt_next = 4'h0;
        end
      end
      SGP_EX_RATIO: begin
        ratioLow_next = SGP_RATIO_FULL;
        stepCnt_next = stepCnt_reg + 4'h1;
        if (stepDone) begin
          state_next = SGP_NORMAL;
        end
      end
      default: state_next = SGP_NORMAL;
    endcase
  end

  // Reset while stopped reinitializes everything but the grant state
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg <= inGrant ? SGP_GRANT : SGP_NORMAL;
      grantCnt_reg <= 5'd0;
      stepCnt_reg <= 4'h0;
      ratioLow_reg <= SGP_RATIO_FULL;
      vidLow_reg <= SGP_VID_FULL;
      flush_reg <= 2'd0;
    end else begin
      if (!syncReady) begin
        flush_reg <= flush_reg + 2'd1;
      end
      state_reg <= state_next;
      grantCnt_reg <= grantCnt_next;
      stepCnt_reg <= stepCnt_next;
      ratioLow_reg <= ratioLow_next;
      vidLow_reg <= vidLow_next;
    end
  end

  // Pending events: replayed latch, or live edges outside stop-grant
  always_ff @(posedge clk) begin
    if (!rstn) begin
      latched_reg <= '0;
      evPrev_reg <= '0;
      pend_reg <= '0;
    end else begin
      latched_reg <= latched_next;
      evPrev_reg <= rawEvents;
      // New event wins over the consumer's clear
      pend_reg <= (pend_reg & ~{SGP_NUM_EVENTS{eventTaken}})
        | (replay ? latched_reg : '0)
        | ((inGrant && !replay) ? '0 : evRise);
    end
  end

  assign ackCycleRequest = (state_reg == SGP_ACK_REQ);
  assign eventPending = pend_reg;
  assign stopGranted = inGrant;
  assign inSnoop = (state_reg == SGP_GRANT_SNOOP) || (state_reg == SGP_HALT_SNOOP)
    || (state_reg == SGP_EH_SNOOP);
  assign inHalt = inHaltAny || (state_reg == SGP_HALT_SNOOP) || (state_reg == SGP_EH_SNOOP);
  assign coreRatioLow = ratioLow_reg;
  assign voltageIdLow = vidLow_reg;
  assign powerState = state_reg;

  property p_grant_delay;
    @(posedge clk) disable iff (!rstn)
    (state_reg == SGP_ACK_WAIT && ackResponseDone) |-> ##21 (state_reg == SGP_GRANT)
      || !stopReq;
  endproperty
  a_grant_delay: assert property (p_grant_delay) else $error("grant delay wrong");

  property p_ack_first;
    @(posedge clk) disable iff (!rstn)
    $rose(state_reg == SGP_GRANT_CNT) |-> $past(state_reg) == SGP_ACK_WAIT;
  endproperty
  a_ack_first: assert property (p_ack_first) else $error("count without ack");

  property p_latch_grant;
    @(posedge clk) disable iff (!rstn)
    (state_reg == SGP_GRANT && stopReq && evRise[SGP_EV_BUS_INIT_ERROR_N])
      |=> latched_reg[SGP_EV_BUS_INIT_ERROR_N] && !pend_reg[SGP_EV_BUS_INIT_ERROR_N];
  endproperty
  a_latch_grant: assert property (p_latch_grant) else $error("event not held");

  property p_exit_grant;
    @(posedge clk) disable iff (!rstn)
    replay |=> state_reg == SGP_NORMAL;
  endproperty
  a_exit_grant: assert property (p_exit_grant) else $error("no exit");

  property p_replay_once;
    @(posedge clk) disable iff (!rstn)
    replay |=> latched_reg == '0 && ((pend_reg & $past(latched_reg)) == $past(latched_reg));
  endproperty
  a_replay_once: assert property (p_replay_once) else $error("replay wrong");

  property p_snoop_enter;
    @(posedge clk) disable iff (!rstn)
    (state_reg == SGP_HALT && snoopSync && !breakEvent) |=> state_reg == SGP_HALT_SNOOP;
  endproperty
  a_snoop_enter: assert property (p_snoop_enter) else $error("snoop missed");

  property p_snoop_stay;
    @(posedge clk) disable iff (!rstn)
    (inSnoop && snoopSync) |=> inSnoop;
  endproperty
  a_snoop_stay: assert property (p_snoop_stay) else $error("snoop left early");

  property p_eh_point;
    @(posedge clk) disable iff (!rstn)
    (state_reg == SGP_EH_SNOOP) |-> coreRatioLow && voltageIdLow;
  endproperty
  a_eh_point: assert property (p_eh_point) else $error("point lost");

  property p_entry_order;
    @(posedge clk) disable iff (!rstn)
    $rose(voltageIdLow) |-> $past(coreRatioLow);
  endproperty
  a_entry_order: assert property (p_entry_order) else $error("vid before ratio");

  property p_exit_order;
    @(posedge clk) disable iff (!rstn)
    $fell(coreRatioLow) |-> !$past(voltageIdLow);
  endproperty
  a_exit_order: assert property (p_exit_order) else $error("ratio before vid");
endmodule

// File: inc/sgp_pkg.sv
package sgp_pkg;
  // Bus clocks from the acknowledge response phase to stop-grant
  localparam logic [4:0] SGP_GRANT_DELAY = 5'd20;
  // Clocks until the pin synchronisers hold real values again after a reset
  localparam logic [1:0] SGP_SYNC_FLUSH = 2'd2;
  localparam int SGP_NUM_EVENTS = 5;
  // Event bit positions
  localparam int SGP_EV_SMI = 0;
  localparam int SGP_EV_INIT = 1;
  localparam int SGP_EV_BUS_INIT_ERROR_N = 2;
  localparam int SGP_EV_LINT0 = 3;
  localparam int SGP_EV_LINT1 = 4;
  // Final count of each enhanced halt ratio/voltage step; the count runs 0 to 8, so a step lasts 9 cycles
  localparam logic [3:0] SGP_STEP_CYCLES = 4'd8;
  localparam logic SGP_RATIO_FULL = 1'b0;
  localparam logic SGP_RATIO_LOW = 1'b1;
  localparam logic SGP_VID_FULL = 1'b0;
  localparam logic SGP_VID_LOW = 1'b1;

  typedef enum logic [3:0] {
    SGP_NORMAL = 4'h0,
    SGP_ACK_REQ = 4'h1,
    SGP_ACK_WAIT = 4'h2,
    SGP_GRANT_CNT = 4'h3,
    SGP_GRANT = 4'h4,
    SGP_GRANT_SNOOP = 4'h5,
    SGP_HALT = 4'h6,
    SGP_HALT_SNOOP = 4'h7,
    SGP_EH_RATIO = 4'h8,
    SGP_EH_VID = 4'h9,
    SGP_EHALT = 4'ha,
    SGP_EH_SNOOP = 4'hb,
    SGP_EX_VID = 4'hc,
    SGP_EX_RATIO = 4'hd
  } sgp_state_type;
endpackage

// File: hw/sgp_sync.sv
`timescale 1ns/1ps
module sgp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  // First stage feeds only the second one
  always_ff @(posedge clk) begin
    if (!rstn) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= asyncIn;
      stage2_reg <= stage1_reg;
    end
  end

  assign syncOut = stage2_reg;
endmodule

// File: test/sgp_agent_model.sv
`timescale 1ns/1ps
module sgp_agent_model #(
  parameter int ACK_DELAY = 3,
  parameter int SNOOP_LEN = 6
) (
  input wire logic clk,
  input wire logic stopCmd,
  input wire logic snoopCmd,
  input wire logic ackCycleRequest,
  output logic stopClockRequest_n,
  output logic ackResponseDone,
  output logic snoopActive
);
  int snoopCnt = 0;
  int ackCnt = 0;
  // Pin stays inactive unless the bench commands a stop
  assign stopClockRequest_n = !stopCmd;
  assign snoopActive = snoopCnt > 0;
  // Driven on the edge so the bench and the design never race on the pulse
  always @(posedge clk) begin
    ackResponseDone <= (ackCnt == 1);
    if (ackCycleRequest) begin
      ackCnt <= ACK_DELAY;
    end else if (ackCnt > 0) begin
      ackCnt <= ackCnt - 1;
    end
  end
  // Snoop stays unserviced for a while, so the snoop state is held
  always @(posedge clk) begin
    if (snoopCmd) begin
      snoopCnt <= SNOOP_LEN;
    end else if (snoopCnt > 0) begin
      snoopCnt <= snoopCnt - 1;
    end
  end
endmodule

// File: test/stop_grant_snoop_power_states_bench.sv
`timescale 1ns/1ps
module stop_grant_snoop_power_states_bench;
  import sgp_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic stopCmd = 1'b0;
  logic snoopCmd = 1'b0;
  logic busInitError_n = 1'b1;
  logic systemMgmtInterrupt_n = 1'b1;
  logic softInit_n = 1'b1;
  logic [1:0] lint = 2'b00;
  logic haltRequest = 1'b0;
  logic ehEn = 1'b0;
  logic eventTaken = 1'b0;
  wire stopN, ack, snoop, ackReq, granted, inSnoop, inHalt, ratioLow, vidLow;
  wire [4:0] pending;
  wire [3:0] powerState;
  wire [5:0] mon = {vidLow, ratioLow, inHalt, inSnoop, granted, ack};
  int error_cnt = 0;
  int checks_done = 0;

  always #4 clk = ~clk;

  sgp_agent_model model (.clk(clk), .stopCmd(stopCmd), .snoopCmd(snoopCmd),
    .ackCycleRequest(ackReq), .stopClockRequest_n(stopN), .ackResponseDone(ack),
    .snoopActive(snoop));

  sgp_power_ctrl uut (.clk(clk), .rstn(rstn), .stopClockRequest_n(stopN),
    .busInitError_n(busInitError_n), .systemMgmtInterrupt_n(systemMgmtInterrupt_n),
    .softInit_n(softInit_n), .localInterruptInputs(lint), .snoopActive(snoop),
    .haltRequest(haltRequest), .enhancedHaltEnable(ehEn), .ackResponseDone(ack),
    .eventTaken(eventTaken), .ackCycleRequest(ackReq), .eventPending(pending),
    .stopGranted(granted), .inSnoop(inSnoop), .inHalt(inHalt),
    .coreRatioLow(ratioLow), .voltageIdLow(vidLow), .powerState(powerState));

  task automatic finish_test;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chkVal(input logic [4:0] got, input logic [4:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chkState(input logic [3:0] got, input logic [3:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t state %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic waitSig(input int sel, input logic val);
    for (int i = 0; i < 200; i++) begin
      tick(1);
      if (mon[sel] === val) return;
    end
    error_cnt++;
    $display("[ERR] %0t wait %h exp %h", $time, sel, val);
    finish_test();
  endtask

  task automatic pulseTaken;
    eventTaken = 1'b1;
    tick(1);
    eventTaken = 1'b0;
  endtask

  task automatic snoopOnce;
    snoopCmd = 1'b1;
    tick(1);
    snoopCmd = 1'b0;
    waitSig(2, 1'b1);
  endtask

  task automatic scnGrant;
    stopCmd = 1'b1;
    tick(3);
    chkVal(5'(ackReq), 5'h01);
    waitSig(0, 1'b1);
    tick(20);
    chkVal(5'(granted), 5'h00);
    tick(1);
    chkVal(5'(granted), 5'h01);
    rstn = 1'b0;
    tick(3);
    rstn = 1'b1;
    tick(3);
    chkVal(5'(granted), 5'h01);
    // Two bursts of every event: only one of each may come out
    repeat (2) begin
      {systemMgmtInterrupt_n, softInit_n, busInitError_n, lint} = 5'h03;
      tick(3);
      {systemMgmtInterrupt_n, softInit_n, busInitError_n, lint} = 5'h1c;
      tick(3);
    end
    chkVal(5'(granted), 5'h01);
    chkVal(pending, 5'h00);
    stopCmd = 1'b0;
    waitSig(1, 1'b0);
    chkState(powerState, SGP_NORMAL);
    chkVal(pending, 5'h1f);
    pulseTaken();
    tick(4);
    chkVal(pending, 5'h00);
  endtask

  task automatic scnGrantSnoop;
    stopCmd = 1'b1;
    waitSig(1, 1'b1);
    snoopOnce();
    chkState(powerState, SGP_GRANT_SNOOP);
    tick(3);
    chkVal(5'(inSnoop), 5'h01);
    waitSig(2, 1'b0);
    chkState(powerState, SGP_GRANT);
    stopCmd = 1'b0;
    waitSig(1, 1'b0);
  endtask

  task automatic scnHalt;
    ehEn = 1'b0;
    haltRequest = 1'b1;
    waitSig(3, 1'b1);
    stopCmd = 1'b1;
    tick(6);
    stopCmd = 1'b0;
    tick(8);
    chkState(powerState, SGP_HALT);
    snoopOnce();
    chkState(powerState, SGP_HALT_SNOOP);
    waitSig(2, 1'b0);
    chkState(powerState, SGP_HALT);
    haltRequest = 1'b0;
    softInit_n = 1'b0;
    waitSig(3, 1'b0);
    chkState(powerState, SGP_NORMAL);
    chkVal(pending, 5'h02);
    softInit_n = 1'b1;
    tick(3);
    pulseTaken();
  endtask

  task automatic scnEhalt;
    ehEn = 1'b1;
    haltRequest = 1'b1;
    waitSig(4, 1'b1);
    chkVal(5'(vidLow), 5'h00);
    waitSig(5, 1'b1);
    chkVal(5'(ratioLow), 5'h01);
    tick(12);
    chkState(powerState, SGP_EHALT);
    snoopOnce();
    chkState(powerState, SGP_EH_SNOOP);
    chkVal(5'({ratioLow, vidLow}), 5'h03);
    waitSig(2, 1'b0);
    chkState(powerState, SGP_EHALT);
    haltRequest = 1'b0;
    lint = 2'b01;
    waitSig(5, 1'b0);
    chkVal(5'(ratioLow), 5'h01);
    chkVal(pending, 5'h08);
    waitSig(4, 1'b0);
    lint = 2'b00;
    // The ratio step runs its full settle time before normal is reached
    tick(int'(SGP_STEP_CYCLES));
    chkState(powerState, SGP_NORMAL);
    pulseTaken();
  endtask

  initial begin
    tick(8);
    rstn = 1'b1;
    tick(3);
    scnGrant();
    scnGrantSnoop();
    scnHalt();
    scnEhalt();
    finish_test();
  end
endmodule
